// ---- rtl/timer16_consts.svh ----
// Purpose: offsets, field positions, limits and reset values of the 16-bit timer
// Assumes: 32-bit Avalon-MM slave, one byte register per aligned word
// Notes: definitions only
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

// ***************************************************
// register byte addresses
// ***************************************************
`define T16_OFS_CNT_LO 8'h00
`define T16_OFS_CNT_HI 8'h04
`define T16_OFS_CMPA_LO 8'h08
`define T16_OFS_CMPA_HI 8'h0C
`define T16_OFS_CMPB_LO 8'h10
`define T16_OFS_CMPB_HI 8'h14
`define T16_OFS_CAP_LO 8'h18
`define T16_OFS_CAP_HI 8'h1C
`define T16_OFS_CTRL_A 8'h20
`define T16_OFS_CTRL_B 8'h24
`define T16_OFS_CTRL_C 8'h28
`define T16_OFS_FLAGS 8'h2C
`define T16_OFS_MASK 8'h30

// ***************************************************
// field positions
// ***************************************************
`define T16_CS_MSB 2
`define T16_WGMH_LSB 3
`define T16_EDGE_BIT 6
`define T16_FILT_BIT 7
`define T16_SRC_BIT 0
`define T16_FLG_OVF 0
`define T16_FLG_CMPA 1
`define T16_FLG_CMPB 2
`define T16_FLG_CAP 3

// ***************************************************
// limits and reset values
// ***************************************************
`define T16_ZERO_LIMIT 16'h0000
`define T16_MAX 16'hFFFF
`define T16_TOP_8 16'h00FF
`define T16_TOP_9 16'h01FF
`define T16_TOP_10 16'h03FF
`define T16_RST_BYTE 8'h00
`define T16_RST_WORD 16'h0000
`endif

// ---- rtl/timer16_pkg.sv ----
// Purpose: types shared by the 16-bit timer
// Assumes: nothing
// Notes: constants live in timer16_consts.svh
package timer16_pkg;
	// ***************************************************
	// types
	// ***************************************************
	typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} bus_state_type;
	typedef enum logic [2:0] {
		CS_NONE = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
		CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
	} clock_sel_type;
	typedef struct packed {
		logic capture;
		logic cmp_b;
		logic cmp_a;
		logic overflow;
	} flag_set_type;
endpackage

// ---- rtl/timer16_byte_access_core.sv ----
// Purpose: 16-bit timer/counter with byte-wide register access via a shared high byte
// Assumes: 40 MHz i_clk, Avalon-MM master with waitrequest, async pins
// Notes: counter counts up only; waveform pins are not produced here
`timescale 1ns/1ps
`include "timer16_consts.svh"

module timer16_byte_access_core #(
	parameter int FILTER_LEN = 4,
	parameter int PRE_W = 10
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_external_count_pin,
	input wire logic i_capture_input_pin,
	input wire logic i_comparator_out,
	input wire logic [3:0] i_irq_executed,
	output logic [3:0] o_irq_request
);
	// ***************************************************
	// input synchronisers, noise filter, edge state
	// ***************************************************
	logic [2:0] sync1_reg, sync2_reg;
	logic [FILTER_LEN-1:0] filt_hist_reg, filt_hist_next;
	logic cap_level_reg, cap_level_next;
	logic ext_prev_reg;
	logic cap_src;
	logic cap_filtered;
	logic cap_event;
	logic ext_rise, ext_fall;
	logic [7:0] ctrl_a_reg, ctrl_a_next;
	logic [7:0] ctrl_b_reg, ctrl_b_next;
	logic [7:0] ctrl_c_reg, ctrl_c_next;

	// pick source, then filter; a source switch may itself look like an edge
	always_comb
	begin
		cap_src = ctrl_c_reg[`T16_SRC_BIT] ? sync2_reg[2] : sync2_reg[1];
		filt_hist_next = {filt_hist_reg[FILTER_LEN-2:0], cap_src};
		cap_filtered = cap_level_reg;
		if (!ctrl_b_reg[`T16_FILT_BIT])
		begin
			cap_filtered = cap_src;
		end
		else if (&filt_hist_next)
		begin
			cap_filtered = 1'b1;
		end
		else if (~|filt_hist_next)
		begin
			cap_filtered = 1'b0;
		end
		cap_level_next = cap_filtered;
		// rising edge when edge bit set, falling otherwise
		cap_event = (cap_filtered != cap_level_reg)
			&& (cap_filtered == ctrl_b_reg[`T16_EDGE_BIT]);
		ext_rise = sync2_reg[0] && !ext_prev_reg;
		ext_fall = !sync2_reg[0] && ext_prev_reg;
	end

	// first stage is read only by the second
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			filt_hist_reg <= '0;
			cap_level_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= {i_comparator_out, i_capture_input_pin, i_external_count_pin};
			sync2_reg <= sync1_reg;
			filt_hist_reg <= filt_hist_next;
			cap_level_reg <= cap_level_next;
			ext_prev_reg <= sync2_reg[0];
		end
	end

	// ***************************************************
	// prescaler and clock selection
	// ***************************************************
	logic [PRE_W-1:0] pre_cnt_reg, pre_cnt_next;
	logic tick;
	timer16_pkg::clock_sel_type clk_sel;

	// tick is the one-cycle timer clock enable
	always_comb
	begin
		clk_sel = timer16_pkg::clock_sel_type'(ctrl_b_reg[`T16_CS_MSB:0]);
		pre_cnt_next = (clk_sel == timer16_pkg::CS_NONE) ? '0 : pre_cnt_reg + 1'b1;
		case (clk_sel)
			timer16_pkg::CS_DIV1: tick = 1'b1;
			timer16_pkg::CS_DIV8: tick = &pre_cnt_reg[2:0];
			timer16_pkg::CS_DIV64: tick = &pre_cnt_reg[5:0];
			timer16_pkg::CS_DIV256: tick = &pre_cnt_reg[7:0];
			timer16_pkg::CS_DIV1024: tick = &pre_cnt_reg[9:0];
			timer16_pkg::CS_EXT_FALL: tick = ext_fall;
			timer16_pkg::CS_EXT_RISE: tick = ext_rise;
			default: tick = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			pre_cnt_reg <= '0;
		end
		else
		begin
			pre_cnt_reg <= pre_cnt_next;
		end
	end

	// ***************************************************
	// counter, compare, capture, flags and bus slave
	// ***************************************************
	timer16_pkg::bus_state_type state_reg, state_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] hold_reg, hold_next;
	logic [15:0] counter_value_reg, counter_value_next;
	logic [15:0] compare_value_a_reg, compare_value_a_next;
	logic [15:0] compare_value_b_reg, compare_value_b_next;
	logic [15:0] cmp_a_act_reg, cmp_a_act_next;
	logic [15:0] cmp_b_act_reg, cmp_b_act_next;
	logic [15:0] capture_value_reg, capture_value_next;
	timer16_pkg::flag_set_type flags_reg, flags_next, flag_set;
	logic [3:0] mask_reg, mask_next;
	logic [3:0] flag_clr;
	logic [3:0] wgm;
	logic [15:0] top;
	logic top_is_cap, pwm_mode, at_top, accept;
	logic [7:0] wbyte;

	always_comb
	begin
		state_next = state_reg;
		rdata_next = rdata_reg;
		hold_next = hold_reg;
		counter_value_next = counter_value_reg;
		compare_value_a_next = compare_value_a_reg;
		compare_value_b_next = compare_value_b_reg;
		cmp_a_act_next = cmp_a_act_reg;
		cmp_b_act_next = cmp_b_act_reg;
		capture_value_next = capture_value_reg;
		ctrl_a_next = ctrl_a_reg;
		ctrl_b_next = ctrl_b_reg;
		ctrl_c_next = ctrl_c_reg;
		mask_next = mask_reg;
		wbyte = i_avs_writedata[7:0];
		wgm = {ctrl_b_reg[`T16_WGMH_LSB+1:`T16_WGMH_LSB], ctrl_a_reg[1:0]};
		top_is_cap = 1'b0;
		// top of the sequence follows the mode
		case (wgm)
			4'h1, 4'h5: top = `T16_TOP_8;
			4'h2, 4'h6: top = `T16_TOP_9;
			4'h3, 4'h7: top = `T16_TOP_10;
			4'h4, 4'h9, 4'hB, 4'hF: top = cmp_a_act_reg;
			4'h8, 4'hA, 4'hC, 4'hE:
			begin
				top = capture_value_reg;
				top_is_cap = 1'b1;
			end
			default: top = `T16_MAX;
		endcase
		pwm_mode = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC || wgm == 4'hD);
		at_top = (counter_value_reg == top);
		// counter advances only on the timer clock; wraps to zero after top
		if (tick)
		begin
			counter_value_next = at_top ? `T16_ZERO_LIMIT : counter_value_reg + 16'h0001;
		end
		// pulse modes load compare values at top so a period never tears
		if (!pwm_mode || (tick && at_top))
		begin
			cmp_a_act_next = compare_value_a_reg;
			cmp_b_act_next = compare_value_b_reg;
		end
		flag_set.overflow = tick && (counter_value_reg == (pwm_mode ? top : `T16_MAX));
		flag_set.cmp_a = tick && (counter_value_reg == cmp_a_act_reg);
		flag_set.cmp_b = tick && (counter_value_reg == cmp_b_act_reg);
		flag_set.capture = cap_event;
		if (cap_event)
		begin
			capture_value_next = counter_value_reg;
		end
		// one wait state: side effects at the first edge, answer at the next
		accept = (i_avs_read || i_avs_write) && (state_reg == timer16_pkg::BUS_IDLE);
		state_next = accept ? timer16_pkg::BUS_ACK : timer16_pkg::BUS_IDLE;
		flag_clr = i_irq_executed;
		if (accept && i_avs_write)
		begin
			case (i_avs_address)
				`T16_OFS_CNT_HI, `T16_OFS_CMPA_HI, `T16_OFS_CMPB_HI, `T16_OFS_CAP_HI:
					hold_next = wbyte;
				`T16_OFS_CNT_LO: counter_value_next = {hold_reg, wbyte};
				`T16_OFS_CMPA_LO: compare_value_a_next = {hold_reg, wbyte};
				`T16_OFS_CMPB_LO: compare_value_b_next = {hold_reg, wbyte};
				`T16_OFS_CAP_LO:
				begin
					// writable only while it defines the top
					if (top_is_cap)
					begin
						capture_value_next = {hold_reg, wbyte};
					end
				end
				`T16_OFS_CTRL_A: ctrl_a_next = wbyte;
				`T16_OFS_CTRL_B: ctrl_b_next = wbyte;
				`T16_OFS_CTRL_C: ctrl_c_next = wbyte;
				`T16_OFS_FLAGS: flag_clr = flag_clr | wbyte[3:0];
				`T16_OFS_MASK: mask_next = wbyte[3:0];
				default: hold_next = hold_reg;
			endcase
		end
		if (accept && i_avs_read)
		begin
			rdata_next = 32'h0000_0000;
			case (i_avs_address)
				`T16_OFS_CNT_LO:
				begin
					rdata_next[7:0] = counter_value_reg[7:0];
					hold_next = counter_value_reg[15:8];
				end
				`T16_OFS_CAP_LO:
				begin
					rdata_next[7:0] = capture_value_reg[7:0];
					hold_next = capture_value_reg[15:8];
				end
				`T16_OFS_CNT_HI, `T16_OFS_CAP_HI: rdata_next[7:0] = hold_reg;
				`T16_OFS_CMPA_LO: rdata_next[7:0] = compare_value_a_reg[7:0];
				`T16_OFS_CMPA_HI: rdata_next[7:0] = compare_value_a_reg[15:8];
				`T16_OFS_CMPB_LO: rdata_next[7:0] = compare_value_b_reg[7:0];
				`T16_OFS_CMPB_HI: rdata_next[7:0] = compare_value_b_reg[15:8];
				`T16_OFS_CTRL_A: rdata_next[7:0] = ctrl_a_reg;
				`T16_OFS_CTRL_B: rdata_next[7:0] = ctrl_b_reg;
				`T16_OFS_CTRL_C: rdata_next[7:0] = ctrl_c_reg;
				`T16_OFS_FLAGS: rdata_next[3:0] = flags_reg;
				`T16_OFS_MASK: rdata_next[3:0] = mask_reg;
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		// a new event beats a clear in the same cycle
		flags_next = (flags_reg & ~flag_clr) | flag_set;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			state_reg <= timer16_pkg::BUS_IDLE;
			rdata_reg <= 32'h0000_0000;
			hold_reg <= `T16_RST_BYTE;
			counter_value_reg <= `T16_RST_WORD;
			compare_value_a_reg <= `T16_RST_WORD;
			compare_value_b_reg <= `T16_RST_WORD;
			cmp_a_act_reg <= `T16_RST_WORD;
			cmp_b_act_reg <= `T16_RST_WORD;
			capture_value_reg <= `T16_RST_WORD;
			ctrl_a_reg <= `T16_RST_BYTE;
			ctrl_b_reg <= `T16_RST_BYTE;
			ctrl_c_reg <= `T16_RST_BYTE;
			flags_reg <= 4'h0;
			mask_reg <= 4'h0;
		end
		else
		begin
			state_reg <= state_next;
			rdata_reg <= rdata_next;
			hold_reg <= hold_next;
			counter_value_reg <= counter_value_next;
			compare_value_a_reg <= compare_value_a_next;
			compare_value_b_reg <= compare_value_b_next;
			cmp_a_act_reg <= cmp_a_act_next;
			cmp_b_act_reg <= cmp_b_act_next;
			capture_value_reg <= capture_value_next;
			ctrl_a_reg <= ctrl_a_next;
			ctrl_b_reg <= ctrl_b_next;
			ctrl_c_reg <= ctrl_c_next;
			flags_reg <= flags_next;
			mask_reg <= mask_next;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	assign o_avs_readdata = rdata_reg;
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (state_reg == timer16_pkg::BUS_IDLE);
	assign o_irq_request = flags_reg & mask_reg;
endmodule

// ---- test/timer16_byte_access_assertions.sv ----
// Purpose: port-level properties of the byte-access timer
// Assumes: one wait cycle per access, mode 0 traffic
// Notes: shadow registers track only what the bus ports reveal
`timescale 1ns/1ps
module timer16_byte_access_assertions (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [3:0] o_irq_request
);
	// ************
	// shadows
	// ************
	logic req, taken, rd_ans;
	logic [7:0] hold_reg;
	logic hold_ok_reg;
	logic [15:0] cmpa_reg;
	logic [3:0] mask_reg;
	assign req = i_avs_read | i_avs_write;
	assign taken = req & o_avs_waitrequest;
	assign rd_ans = i_avs_read & !o_avs_waitrequest;
	// low reads of counter or capture load the holding byte with an unseen value
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			hold_reg <= 8'h00;
			hold_ok_reg <= 1'b1;
			cmpa_reg <= 16'h0000;
			mask_reg <= 4'h0;
		end
		else if (taken && i_avs_write)
		begin
			if (i_avs_address[2] && i_avs_address[1:0] == 2'b00 && i_avs_address < 8'h20)
			begin
				hold_reg <= i_avs_writedata[7:0];
				hold_ok_reg <= 1'b1;
			end
			if (i_avs_address == 8'h08)
				cmpa_reg <= {hold_reg, i_avs_writedata[7:0]};
			if (i_avs_address == 8'h30)
				mask_reg <= i_avs_writedata[3:0];
		end
		else if (taken && (i_avs_address == 8'h00 || i_avs_address == 8'h18))
			hold_ok_reg <= 1'b0;
	end
	// ************
	// properties
	// ************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	AST_ONE_WAIT: assert property (taken |=> !o_avs_waitrequest)
		else $error("request waited more than one cycle");
	AST_IDLE_NO_WAIT: assert property (!req |-> !o_avs_waitrequest)
		else $error("wait raised with no request");
	AST_BYTE_WIDE: assert property (rd_ans |-> o_avs_readdata[31:8] == 24'h000000)
		else $error("read data wider than a byte");
	AST_DATA_STANDS: assert property (!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
		else $error("read data changed without a read");
	AST_UNMAPPED: assert property (rd_ans && (i_avs_address > 8'h30 || i_avs_address[1:0] != 2'b00)
		|-> o_avs_readdata == 32'h00000000)
		else $error("unmapped read not zero");
	AST_MASK_GATE: assert property ((o_irq_request & ~mask_reg) == 4'h0)
		else $error("request without mask bit");
	AST_HOLD_READ: assert property (rd_ans && hold_ok_reg && i_avs_address == 8'h04
		|-> o_avs_readdata[7:0] == hold_reg)
		else $error("high read not the holding byte");
	AST_CMPA_LO: assert property (rd_ans && i_avs_address == 8'h08 |-> o_avs_readdata[7:0] == cmpa_reg[7:0])
		else $error("compare a low byte wrong");
	AST_CMPA_HI: assert property (rd_ans && i_avs_address == 8'h0C |-> o_avs_readdata[7:0] == cmpa_reg[15:8])
		else $error("compare a high byte wrong");
	cover property (rd_ans && i_avs_address == 8'h18);
	cover property (o_irq_request[0]);
	cover property (taken && i_avs_write && i_avs_address == 8'h2C);
endmodule

bind timer16_byte_access_core timer16_byte_access_assertions u_checker (.i_clk, .i_nrst,
	.i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
	.o_avs_waitrequest, .o_irq_request);

// ---- test/cpu_bus_model.sv ----
// Purpose: processor side of the byte bus, one access at a time
// Assumes: slave answers by dropping waitrequest
// Notes: released lines show inverted values so stale data is never trusted
`timescale 1ns/1ps
module cpu_bus_model (
	input wire logic i_clk,
	output logic [7:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata,
	input wire logic [31:0] i_readdata,
	input wire logic i_waitrequest
);
	initial
	begin
		o_address = 8'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h00000000;
	end
	// ************
	// one byte access; callers pair them uninterrupted, high first on write
	// ************
	task automatic access(input logic wr_en, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge i_clk);
		o_address <= a;
		o_read <= !wr_en;
		o_write <= wr_en;
		o_writedata <= {24'h000000, d};
		do @(posedge i_clk); while (i_waitrequest !== 1'b0);
		q = i_readdata;
		o_read <= 1'b0;
		o_write <= 1'b0;
		o_address <= ~a;
		o_writedata <= ~o_writedata;
	endtask
endmodule

// ---- test/timer16_byte_access_core_bench.sv ----
// Purpose: self-checking bench of the byte-access timer
// Assumes: processor model drives the bus, bench drives pins
// Notes: counter is only read while stopped, so the model stays exact
`timescale 1ns/1ps
module timer16_byte_access_core_bench;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [7:0] address;
	logic rd_req, wr_req, waitreq;
	logic [31:0] wdata, rdata, q, v;
	logic cap_pin = 1'b0;
	logic ext_pin = 1'b0;
	logic cmp_out = 1'b0;
	logic [3:0] irq_exec = 4'h0;
	logic [3:0] irq_req;
	int n_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	int model [4];
	int hold = 0;
	always #12.5 i_clk = ~i_clk;
	timer16_byte_access_core #(.FILTER_LEN(4), .PRE_W(10)) u_dut (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_avs_address(address), .i_avs_read(rd_req), .i_avs_write(wr_req),
		.i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_external_count_pin(ext_pin), .i_capture_input_pin(cap_pin), .i_comparator_out(cmp_out),
		.i_irq_executed(irq_exec), .o_irq_request(irq_req));
	cpu_bus_model u_cpu (.i_clk(i_clk), .o_address(address), .o_read(rd_req), .o_write(wr_req),
		.o_writedata(wdata), .i_readdata(rdata), .i_waitrequest(waitreq));
	// ************
	// tasks
	// ************
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// model: high writes fill the holding byte, counter and compare low writes commit it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_cpu.access(1'b1, a, d, q);
		if (a < 8'h20 && a[2])
			hold = d;
		else if (a < 8'h18 && !a[2])
			model[a[4:3]] = hold * 256 + d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		u_cpu.access(1'b0, a, 8'h00, q);
		check(q, exp, what);
	endtask
	task automatic rd16(input logic [7:0] a, input string what);
		int e;
		e = model[a[4:3]];
		rd(a, e & 255, what);
		if (a == 8'h00 || a == 8'h18)
			hold = e >> 8;
		rd(a + 8'h04, e >> 8, what);
	endtask
	// hang guard, far above the few hundred cycles needed
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t timeout", $time);
			finish_test();
		end
	end
	// ************
	// scenarios
	// ************
	initial
	begin
		void'($urandom(32'hFD0A));
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		for (int a = 0; a <= 52; a += 4)
			rd(8'(a), 0, "reset value");
		rd(8'h02, 0, "unmapped");
		$display("test reset done");
		repeat (4)
		begin
			v = $urandom;
			wr(8'h0C, v[15:8]);
			wr(8'h08, v[7:0]);
			wr(8'h14, v[31:24]);
			wr(8'h10, v[23:16]);
			rd16(8'h08, "compare a");
			rd16(8'h10, "compare b");
			rd(8'h04, hold, "holding kept");
		end
		$display("test compare done");
		v = $urandom;
		wr(8'h04, v[15:8]);
		wr(8'h00, v[7:0]);
		repeat (20) @(posedge i_clk);
		rd16(8'h00, "counter idle");
		wr(8'h04, ~v[15:8]);
		rd16(8'h00, "high write only");
		$display("test counter done");
		// wrap plus both matches at full rate, overflow and compare b unmasked
		wr(8'h0C, 8'h00);
		wr(8'h08, 8'h10);
		wr(8'h14, 8'h00);
		wr(8'h10, 8'h20);
		wr(8'h30, 8'h05);
		wr(8'h04, 8'hFF);
		wr(8'h00, 8'hF0);
		wr(8'h24, 8'h01);
		rd(8'h24, 1, "control b");
		repeat (80) @(posedge i_clk);
		wr(8'h24, 8'h00);
		rd(8'h2C, 7, "flags set");
		check({28'h0, irq_req}, 5, "masked requests");
		irq_exec <= 4'h1;
		@(posedge i_clk);
		irq_exec <= 4'h0;
		wr(8'h2C, 8'h02);
		rd(8'h2C, 4, "flags cleared");
		$display("test flags done");
		// spike shorter than the filter is dropped, then a clean edge captures
		v = $urandom;
		wr(8'h04, v[15:8]);
		wr(8'h00, v[7:0]);
		model[3] = model[0];
		wr(8'h24, 8'hC0);
		cap_pin <= 1'b1;
		repeat (2) @(posedge i_clk);
		cap_pin <= 1'b0;
		repeat (12) @(posedge i_clk);
		rd(8'h2C, 4, "spike ignored");
		wr(8'h24, 8'h40);
		cap_pin <= 1'b1;
		repeat (8) @(posedge i_clk);
		rd(8'h2C, 32'hC, "capture flag");
		rd16(8'h18, "capture value");
		irq_exec <= 4'h8;
		@(posedge i_clk);
		irq_exec <= 4'h0;
		rd(8'h2C, 4, "capture cleared");
		$display("test capture done");
		// external pin rises advance the counter one each, prescaler output unused
		cap_pin <= 1'b0;
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h00);
		wr(8'h24, 8'h07);
		repeat (5)
		begin
			ext_pin <= 1'b1;
			repeat (4) @(posedge i_clk);
			ext_pin <= 1'b0;
			repeat (4) @(posedge i_clk);
		end
		wr(8'h24, 8'h00);
		model[0] += 5;
		rd16(8'h00, "external count");
		// comparator as capture source, rising edge, filter off
		wr(8'h28, 8'h01);
		wr(8'h24, 8'h40);
		cmp_out <= 1'b1;
		repeat (8) @(posedge i_clk);
		model[3] = model[0];
		rd(8'h2C, 32'hC, "comparator capture");
		rd16(8'h18, "comparator value");
		$display("test sources done");
		finish_test();
	end
endmodule
